// file: rtl/rts_params.svh
// Constants for the reading trigger sequencer: offsets, fields, reset values
// What this block does
// - Single-shot arm, sync trigger and sync sample: after the arm command a host request gives the first reading, then one per sync event until the count is done.
// - Single-shot arm, sync trigger and a non-sync sample: after the arm command and a host request, one reading per sample event until the count is done.
// - When a single-shot armed sequence completes its count, the arm source becomes hold.
// - Sync arm, auto trigger and sync sample: a host request arms and samples at once, then one reading per further sync event.
// - Sync arm, auto trigger and non-sync sample: after a host request, one reading per sample event until the count is done.
// - Sync arm and external trigger: wait for a host request, then a falling edge on the trigger input, then one reading per sample event.
// - Sync arm and level trigger: wait for a host request, then the level event, then one reading per sample event.
// - Sync arm and line trigger: wait for a host request, then a line zero crossing, then one reading per sample event.
// - Sync for all three stages: one host request satisfies them all and gives the first reading, then one per further sync event.
// - Sync arm and sync trigger with non-sync sample: a host request satisfies both, then one reading per sample event.
// - A sync event counts only while the output buffer is empty and reading memory is off or empty.
// - The level event fires when the input reaches the set level while moving in the set slope direction.
// - The level event may serve as trigger or sample source only for DC voltage or direct-sampled functions.
// - While the arm source is hold, no readings are taken until software picks another arm source.
`ifndef RTS_PARAMS_SVH
`define RTS_PARAMS_SVH
`define RTS_ADR_ARM 8'h00
`define RTS_ADR_TRIG 8'h04
`define RTS_ADR_SAMP 8'h08
`define RTS_ADR_CNT 8'h0c
`define RTS_ADR_TAKEN 8'h10
`define RTS_ADR_STAT 8'h14
`define RTS_ADR_LVL 8'h18
`define RTS_ADR_FUNC 8'h1c
`define RTS_RST_ARM 3'h7
`define RTS_RST_TRIG 3'h0
`define RTS_RST_SAMP 3'h0
`define RTS_RST_CNT 16'h0001
`define RTS_RST_LVL 16'h0000
`define RTS_LVL_SLOPE_BIT 16
`define RTS_STAT_ILLEGAL_BIT 2
`define RTS_STAT_HOLD_BIT 3
`endif

// file: rtl/rts_pkg.sv
// Types shared by the reading trigger sequencer
package rts_pkg;
    typedef enum logic [2:0] {
        SRC_AUTO, SRC_EXT, SRC_TIMER, SRC_LINE,
        SRC_LEVEL, SRC_SYNC, SRC_SINGLE, SRC_HOLD
    } rts_src_t;
    typedef enum logic [1:0] {
        ST_HOLD, ST_ARM, ST_TRIG, ST_SAMP
    } rts_state_t;
    typedef struct packed {
        logic ext_trig;
        logic line_zero;
        logic timer_tick;
        logic host_req;
        logic out_buf_empty;
        logic mem_on;
        logic mem_empty;
        logic signed [15:0] sample;
    } rts_evt_t;
endpackage

// file: rtl/rts_top.sv
// Reading trigger sequencer with a classic Wishbone register slave
`timescale 1ns/1ps
`include "rts_params.svh"
module rts_top (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Event sources and buffer state
    input wire rts_pkg::rts_evt_t evt_i,
    // Sequencer outputs
    output logic reading_o,
    output logic busy_o
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Refuses source pairs the sequencer cannot serve
    function automatic logic legal(input rts_pkg::rts_src_t a,
                                   input rts_pkg::rts_src_t t,
                                   input rts_pkg::rts_src_t s,
                                   input logic dc_fn);
        logic ok;
        ok = 1'b1;
        if (a == rts_pkg::SRC_TIMER || a == rts_pkg::SRC_LINE ||
            a == rts_pkg::SRC_LEVEL) begin
            ok = 1'b0;
        end
        if (t == rts_pkg::SRC_TIMER) begin
            ok = 1'b0;
        end
        if (s == rts_pkg::SRC_SINGLE || s == rts_pkg::SRC_HOLD) begin
            ok = 1'b0;
        end
        if (t == rts_pkg::SRC_SINGLE && a != rts_pkg::SRC_AUTO &&
            a != rts_pkg::SRC_HOLD) begin
            ok = 1'b0;
        end
        if ((t == rts_pkg::SRC_EXT || t == rts_pkg::SRC_LEVEL ||
             t == rts_pkg::SRC_LINE) && s == rts_pkg::SRC_SYNC) begin
            ok = 1'b0;
        end
        if ((t == rts_pkg::SRC_LEVEL && s == rts_pkg::SRC_LINE) ||
            (t == rts_pkg::SRC_LINE && s == rts_pkg::SRC_LEVEL)) begin
            ok = 1'b0;
        end
        if ((t == rts_pkg::SRC_LEVEL || s == rts_pkg::SRC_LEVEL) && !dc_fn) begin
            ok = 1'b0;
        end
        return ok;
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    rts_pkg::rts_src_t arm_r;
    rts_pkg::rts_src_t trig_r;
    rts_pkg::rts_src_t samp_r;
    rts_pkg::rts_state_t state_r;
    rts_pkg::rts_state_t state_nxt;
    logic [15:0] count_r;
    logic [15:0] taken_r;
    logic signed [15:0] level_r;
    logic slope_up_r;
    logic dc_fn_r;
    logic restart_r;
    logic single_cmd_r;
    logic single_req_r;
    logic ext_prev_r;
    logic signed [15:0] prev_sample_r;
    logic bus_req;
    logic bus_wr;
    logic [31:0] rd_word;
    logic [31:0] wr_arm;
    logic [31:0] wr_trig;
    logic [31:0] wr_samp;
    logic [31:0] wr_cnt;
    logic [31:0] wr_lvl;
    logic [31:0] wr_fn;
    logic [7:0] ev;
    logic cfg_ok;
    logic take;
    logic last;
    logic finish;
    logic sync_ev;
    logic level_ev;

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr = bus_req && wb_we_i;
    assign wr_arm = wmerge({29'h0, arm_r}, wb_dat_i, wb_sel_i);
    assign wr_trig = wmerge({29'h0, trig_r}, wb_dat_i, wb_sel_i);
    assign wr_samp = wmerge({29'h0, samp_r}, wb_dat_i, wb_sel_i);
    assign wr_cnt = wmerge({16'h0, count_r}, wb_dat_i, wb_sel_i);
    assign wr_lvl = wmerge({15'h0, slope_up_r, level_r}, wb_dat_i, wb_sel_i);
    assign wr_fn = wmerge({31'h0, dc_fn_r}, wb_dat_i, wb_sel_i);

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    // One-cycle answer; unmapped offsets read zero and still acknowledge
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    always_comb begin
        rd_word = 32'h0;
        unique case (wb_adr_i)
            `RTS_ADR_ARM: rd_word = {29'h0, arm_r};
            `RTS_ADR_TRIG: rd_word = {29'h0, trig_r};
            `RTS_ADR_SAMP: rd_word = {29'h0, samp_r};
            `RTS_ADR_CNT: rd_word = {16'h0, count_r};
            `RTS_ADR_TAKEN: rd_word = {16'h0, taken_r};
            `RTS_ADR_STAT: rd_word = {28'h0, arm_r == rts_pkg::SRC_HOLD,
                                      !cfg_ok, state_r};
            `RTS_ADR_LVL: rd_word = {15'h0, slope_up_r, level_r};
            `RTS_ADR_FUNC: rd_word = {31'h0, dc_fn_r};
            default: rd_word = 32'h0;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            wb_dat_o <= 32'h0;
        end else if (bus_req && !wb_we_i) begin
            wb_dat_o <= rd_word;
        end
    end

    // Arm source; completion of a single-shot run drops it to hold
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            arm_r <= rts_pkg::rts_src_t'(`RTS_RST_ARM);
        end else if (bus_wr && wb_adr_i == `RTS_ADR_ARM) begin
            arm_r <= rts_pkg::rts_src_t'(wr_arm[2:0]);
        end else if (finish && arm_r == rts_pkg::SRC_SINGLE) begin
            arm_r <= rts_pkg::SRC_HOLD;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            trig_r <= rts_pkg::rts_src_t'(`RTS_RST_TRIG);
            samp_r <= rts_pkg::rts_src_t'(`RTS_RST_SAMP);
            count_r <= `RTS_RST_CNT;
            level_r <= `RTS_RST_LVL;
            slope_up_r <= 1'b1;
            dc_fn_r <= 1'b1;
        end else if (bus_wr) begin
            if (wb_adr_i == `RTS_ADR_TRIG) begin
                trig_r <= rts_pkg::rts_src_t'(wr_trig[2:0]);
            end
            if (wb_adr_i == `RTS_ADR_SAMP) begin
                samp_r <= rts_pkg::rts_src_t'(wr_samp[2:0]);
            end
            if (wb_adr_i == `RTS_ADR_CNT) begin
                count_r <= wr_cnt[15:0];
            end
            if (wb_adr_i == `RTS_ADR_LVL) begin
                level_r <= wr_lvl[15:0];
                slope_up_r <= wr_lvl[`RTS_LVL_SLOPE_BIT];
            end
            if (wb_adr_i == `RTS_ADR_FUNC) begin
                dc_fn_r <= wr_fn[0];
            end
        end
    end

    // A write to arm, trigger, sample or count restarts the sequence; single-shot command pulses
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            restart_r <= 1'b0;
            single_req_r <= 1'b0;
            single_cmd_r <= 1'b0;
        end else begin
            restart_r <= bus_wr && (wb_adr_i == `RTS_ADR_ARM ||
                         wb_adr_i == `RTS_ADR_TRIG || wb_adr_i == `RTS_ADR_SAMP ||
                         wb_adr_i == `RTS_ADR_CNT);
            single_req_r <= bus_wr && wr_arm[2:0] == 3'h6 &&
                            (wb_adr_i == `RTS_ADR_ARM || wb_adr_i == `RTS_ADR_TRIG);
            // One cycle late, so the command lands after the restart it rides with
            single_cmd_r <= single_req_r;
        end
    end

    // ------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            ext_prev_r <= 1'b1;
            prev_sample_r <= 16'sh0000;
        end else begin
            ext_prev_r <= evt_i.ext_trig;
            prev_sample_r <= evt_i.sample;
        end
    end

    // A data request is ignored while readings are still waiting to go out
    assign sync_ev = evt_i.host_req && evt_i.out_buf_empty &&
                     (!evt_i.mem_on || evt_i.mem_empty);
    assign level_ev = dc_fn_r && (slope_up_r ?
                      (prev_sample_r < level_r && evt_i.sample >= level_r) :
                      (prev_sample_r > level_r && evt_i.sample <= level_r));

    always_comb begin
        ev = 8'h0;
        ev[rts_pkg::SRC_AUTO] = 1'b1;
        ev[rts_pkg::SRC_EXT] = ext_prev_r && !evt_i.ext_trig;
        ev[rts_pkg::SRC_TIMER] = evt_i.timer_tick;
        ev[rts_pkg::SRC_LINE] = evt_i.line_zero;
        ev[rts_pkg::SRC_LEVEL] = level_ev;
        ev[rts_pkg::SRC_SYNC] = sync_ev;
        ev[rts_pkg::SRC_SINGLE] = single_cmd_r;
        ev[rts_pkg::SRC_HOLD] = 1'b0;
    end

    assign cfg_ok = legal(arm_r, trig_r, samp_r, dc_fn_r);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Stages cascade within one cycle, so one host request can satisfy
    // arm, trigger and sample together
    always_comb begin
        state_nxt = state_r;
        take = 1'b0;
        unique case (state_r)
            rts_pkg::ST_HOLD: begin
                state_nxt = rts_pkg::ST_HOLD;
            end
            rts_pkg::ST_ARM: begin
                if (cfg_ok && ev[arm_r]) begin
                    if (ev[trig_r]) begin
                        take = ev[samp_r];
                        state_nxt = rts_pkg::ST_SAMP;
                    end else begin
                        state_nxt = rts_pkg::ST_TRIG;
                    end
                end
            end
            rts_pkg::ST_TRIG: begin
                if (cfg_ok && ev[trig_r]) begin
                    take = ev[samp_r];
                    state_nxt = rts_pkg::ST_SAMP;
                end
            end
            rts_pkg::ST_SAMP: begin
                take = cfg_ok && ev[samp_r];
            end
        endcase
        // Setup writes win over completion; busy_o then tracks the real state
        if (restart_r) begin
            state_nxt = (arm_r == rts_pkg::SRC_HOLD) ? rts_pkg::ST_HOLD : rts_pkg::ST_ARM;
        end else if (take && last) begin
            state_nxt = (arm_r == rts_pkg::SRC_SINGLE) ? rts_pkg::ST_HOLD
                                                        : rts_pkg::ST_ARM;
        end
    end

    assign last = (taken_r + 16'h0001) >= count_r;
    assign finish = take && last && !restart_r;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            state_r <= rts_pkg::ST_HOLD;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            taken_r <= 16'h0;
        end else if (restart_r || finish) begin
            taken_r <= 16'h0;
        end else if (take) begin
            taken_r <= taken_r + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            reading_o <= 1'b0;
            busy_o <= 1'b0;
        end else begin
            reading_o <= take && !restart_r;
            busy_o <= state_nxt != rts_pkg::ST_HOLD;
        end
    end
endmodule

// file: tb/rts_top_sva.sv
// Port-level checker for the reading trigger sequencer
`timescale 1ns/1ps
module rts_top_sva (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Sequencer outputs
    input wire logic reading_o,
    input wire logic busy_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack_once;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    sequence s_idle;
        (!busy_o && !wb_ack_o) [*2];
    endsequence
    AST_ACK_NEXT: assert property (s_req |=> s_ack_once)
        else $error("ack not a single pulse one cycle after request");
    AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
        else $error("ack without a request");
    AST_DAT_HOLD: assert property (!wb_ack_o |-> $stable(wb_dat_o))
        else $error("read data changed without an access");
    AST_READ_BUSY: assert property (reading_o |-> busy_o || $past(busy_o))
        else $error("reading while sequencer idle");
    AST_RESET_QUIET: assert property ($past(reset_i) |-> !reading_o && !busy_o && !wb_ack_o)
        else $error("outputs active right after reset");
    AST_BUSY_CAUSE: assert property ($rose(busy_o) |->
        $past(wb_ack_o) || $past(wb_ack_o, 2))
        else $error("sequencer left hold without a setup write");
    AST_BUSY_END: assert property ($fell(busy_o) |-> reading_o || $past(reading_o) ||
        $past(wb_ack_o) || $past(wb_ack_o, 2))
        else $error("sequencer went to hold without a final reading or write");
    AST_HOLD_QUIET: assert property (s_idle |=> !reading_o)
        else $error("reading taken in hold");
endmodule
bind rts_top rts_top_sva u_rts_top_sva (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .reading_o(reading_o), .busy_o(busy_o));

// file: tb/rts_host_model.sv
// Host controller model: sends one data request after a chosen delay
`timescale 1ns/1ps
module rts_host_model (
    // Clock
    input wire logic sys_clk_i,
    // Command from the bench
    input wire logic ask_i,
    input wire logic [3:0] lag_i,
    // Data request toward the sequencer
    output logic host_req_o
);
    // Request is a bare pulse, so no line terminator ever reaches the device
    initial begin
        host_req_o = 1'b0;
        forever begin
            @(posedge sys_clk_i);
            if (ask_i) begin
                repeat (lag_i) @(posedge sys_clk_i);
                host_req_o <= 1'b1;
                @(posedge sys_clk_i);
                host_req_o <= 1'b0;
            end
        end
    end
endmodule

// file: tb/tb.sv
// Self-checking bench for the reading trigger sequencer
`timescale 1ns/1ps
`include "rts_params.svh"
module tb;
    localparam logic [2:0] AU = rts_pkg::SRC_AUTO, EX = rts_pkg::SRC_EXT, TI = rts_pkg::SRC_TIMER;
    localparam logic [2:0] LN = rts_pkg::SRC_LINE, LV = rts_pkg::SRC_LEVEL, SY = rts_pkg::SRC_SYNC;
    localparam logic [2:0] SG = rts_pkg::SRC_SINGLE, HD = rts_pkg::SRC_HOLD;
    logic sys_clk_i, reset_i, cyc, stb, we, ask, ext, line, tick, obe, mon, memp, hreq;
    logic ack, reading, busy;
    logic [7:0] adr;
    logic [3:0] lag;
    logic [31:0] wdat, rdat, q;
    logic signed [15:0] smp;
    logic [7:0] ra[7] = '{`RTS_ADR_ARM, `RTS_ADR_TRIG, `RTS_ADR_SAMP, `RTS_ADR_CNT,
        `RTS_ADR_TAKEN, `RTS_ADR_FUNC, 8'h20};
    logic [31:0] rv[7] = '{32'h7, 32'h0, 32'h0, 32'h1, 32'h0, 32'h1, 32'h0};
    logic [2:0] il[18] = '{SY, SG, AU, SY, EX, SY, SY, LV, SY, SY, LN, SY, SY, LV, LN, SY, LN, LV};
    int errors = 0, n_checks = 0, nread = 0, cyc_cnt = 0;
    rts_top u_rts_top (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .evt_i({ext, line, tick, hreq, obe, mon, memp, smp}),
        .reading_o(reading), .busy_o(busy));
    rts_host_model u_rts_host_model (.sys_clk_i(sys_clk_i), .ask_i(ask), .lag_i(lag),
        .host_req_o(hreq));
    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        cyc_cnt++;
        if (reading === 1'b1)
            nread++;
        if (cyc_cnt == 20000) begin
            errors++;
            $display("BAD %0t run too long", $time);
            test_done;
        end
    end
    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        chk({31'h0, ack}, 32'h1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge sys_clk_i);
    endtask
    // One event of kind k; a level event flips the input across the threshold
    task automatic ev(input logic [2:0] k);
        int w;
        w = 0;
        ask <= (k == SY);
        lag <= 4'($urandom_range(0, 6));
        ext <= (k != EX);
        line <= (k == LN);
        tick <= (k == TI);
        if (k == LV)
            smp <= -smp;
        @(posedge sys_clk_i);
        ask <= 1'b0;
        ext <= 1'b1;
        line <= 1'b0;
        tick <= 1'b0;
        while (k == SY && hreq !== 1'b1 && w < 30) begin
            @(posedge sys_clk_i);
            w++;
        end
        repeat (2) @(posedge sys_clk_i);
    endtask
    task automatic scen(input logic [2:0] a, t, s, input int n, input logic ill);
        int base, w, exp;
        exp = (ill || a == HD) ? 0 : n;
        bus(1'b1, `RTS_ADR_CNT, 32'(n));
        bus(1'b1, `RTS_ADR_SAMP, 32'(s));
        bus(1'b1, `RTS_ADR_TRIG, 32'(t));
        bus(1'b1, `RTS_ADR_ARM, 32'(a));
        base = nread;
        if (a == SY || t == SY)
            ev(SY);
        if (t == EX || t == LN || t == LV)
            ev(t);
        for (int i = (s == SY) ? 1 : 0; i < n; i++)
            ev(s);
        w = 0;
        while (nread - base < exp && w < 80) begin
            @(posedge sys_clk_i);
            w++;
        end
        repeat (4) @(posedge sys_clk_i);
        chk(32'(nread - base), 32'(exp));
        bus(1'b0, `RTS_ADR_STAT, 32'h0);
        chk({31'h0, q[`RTS_STAT_ILLEGAL_BIT]}, {31'h0, ill});
    endtask
    initial begin
        int n, base;
        reset_i = 1'b1;
        {cyc, stb, we, ask, line, tick, mon, memp} = 8'h00;
        {ext, obe} = 2'h3;
        adr = 8'h00;
        lag = 4'h0;
        wdat = 32'h0;
        smp = 16'hff38;
        void'($urandom(67037));
        repeat (2) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        bus(1'b1, `RTS_ADR_TAKEN, 32'h5);
        bus(1'b1, 8'h20, 32'h5);
        for (int i = 0; i < 7; i++) begin
            bus(1'b0, ra[i], 32'h0);
            chk(q, rv[i]);
        end
        scen(HD, SY, SY, 2, 1'b0);
        n = $urandom_range(1, 4);
        scen(SG, SY, SY, n, 1'b0);
        bus(1'b0, `RTS_ADR_ARM, 32'h0);
        chk(q, 32'h7);
        chk({31'h0, busy}, 32'h0);
        scen(SG, SY, TI, $urandom_range(1, 4), 1'b0);
        scen(SY, AU, SY, $urandom_range(1, 4), 1'b0);
        scen(SY, AU, AU, $urandom_range(1, 4), 1'b0);
        scen(SY, EX, LN, $urandom_range(1, 4), 1'b0);
        for (int i = 0; i < 2; i++) begin
            bus(1'b1, `RTS_ADR_LVL, {15'h0, smp[15], 16'h0064});
            scen(SY, LV, TI, $urandom_range(1, 4), 1'b0);
        end
        scen(SY, LN, EX, $urandom_range(1, 4), 1'b0);
        scen(SY, SY, TI, $urandom_range(1, 4), 1'b0);
        scen(SY, SY, SY, 3, 1'b0);
        // Blocked requests first, then one that meets all conditions
        base = nread;
        obe <= 1'b0;
        ev(SY);
        obe <= 1'b1;
        mon <= 1'b1;
        ev(SY);
        memp <= 1'b1;
        ev(SY);
        mon <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        chk(32'(nread - base), 32'h1);
        bus(1'b0, `RTS_ADR_TAKEN, 32'h0);
        chk(q, 32'h1);
        bus(1'b1, `RTS_ADR_FUNC, 32'h0);
        scen(SY, LV, TI, 2, 1'b1);
        bus(1'b1, `RTS_ADR_FUNC, 32'h1);
        for (int i = 0; i < 18; i += 3)
            scen(il[i], il[i + 1], il[i + 2], 1, 1'b1);
        test_done;
    end
endmodule
